//--- gate_seq_consts.svh
// Constants for the dual buck gate sequencer
`ifndef GATE_SEQ_CONSTS_SVH
`define GATE_SEQ_CONSTS_SVH
`define CLK_PERIOD_NS     40
`define DEAD_TIME_NS      30
`define DEAD_CYCLES       ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_DIV_DEFAULT   16
`define PWM_BITS          8
`endif

//--- gate_seq_pkg.sv
// Types for the dual buck gate sequencer
`default_nettype none
package gate_seq_pkg;
	typedef enum logic [2:0] {
		SQ_OFF,
		SQ_WAIT_ZERO,
		SQ_START1,
		SQ_START2,
		SQ_RUN,
		SQ_STOP2,
		SQ_STOP1
	} seq_state_t;
	typedef enum logic [1:0] {
		PH_LS_ON,
		PH_LS_OFF,
		PH_HS_ON,
		PH_DEAD
	} phase_t;
endpackage
`default_nettype wire

//--- dual_buck_gate_sequencer.sv
// Gate drive and power sequencing for two synchronous buck regulators
`timescale 1ns/100ps
`default_nettype none
`include "gate_seq_consts.svh"
module dual_buck_gate_sequencer #(
	parameter int OSC_DIV   = `OSC_DIV_DEFAULT,
	parameter int DEAD_CYC  = `DEAD_CYCLES
) (
	input  wire logic                 CLK_SYS,
	input  wire logic                 RST,
	input  wire logic                 CE,
	input  wire logic                 ENABLE,
	input  wire logic                 SUPPLY_ABOVE_LOCKOUT,
	input  wire logic                 SUPPLY_BELOW_RELEASE,
	input  wire logic                 OUT1_AT_ZERO,
	input  wire logic                 SS1_DONE,
	input  wire logic                 SS2_DONE,
	input  wire logic                 SOFTSTOP1_DONE,
	input  wire logic                 SOFTSTOP2_DONE,
	input  wire logic                 ILIM1_OVER,
	input  wire logic                 ILIM2_OVER,
	input  wire logic                 LS1_SENSE_OFF,
	input  wire logic                 LS2_SENSE_OFF,
	input  wire logic [`PWM_BITS-1:0] DUTY1,
	input  wire logic [`PWM_BITS-1:0] DUTY2,
	output logic                      HS_GATE_REG1,
	output logic                      LS_GATE_REG1,
	output logic                      HS_GATE_REG2,
	output logic                      LS_GATE_REG2,
	output logic                      SWITCH_CLK,
	output logic                      LOCKOUT
);
	// Divider and on-time counters are eight bits wide
	if (OSC_DIV < 4 || OSC_DIV > 256 || OSC_DIV % 2 != 0)
		$error("OSC_DIV must be even, 4..256");
	if (DEAD_CYC < 1 || DEAD_CYC > 15)
		$error("DEAD_CYC must be 1..15");

	// Two-flop synchronisers for all asynchronous inputs
	localparam int NS = 10;
	logic [NS-1:0] s1_r;
	logic [NS-1:0] s2_r;
	logic [NS-1:0] s_nxt;
	always_comb begin
		s_nxt = {ENABLE, SUPPLY_ABOVE_LOCKOUT, SUPPLY_BELOW_RELEASE, OUT1_AT_ZERO, SS1_DONE,
			SS2_DONE, SOFTSTOP1_DONE, SOFTSTOP2_DONE, ILIM1_OVER, ILIM2_OVER};
	end
	logic [1:0] lsoff1_r;
	logic [1:0] lsoff2_r;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			s1_r     <= '0;
			s2_r     <= '0;
			lsoff1_r <= 2'h0;
			lsoff2_r <= 2'h0;
		end else if (CE) begin
			s1_r     <= s_nxt;
			s2_r     <= s1_r;
			lsoff1_r <= {lsoff1_r[0], LS1_SENSE_OFF};
			lsoff2_r <= {lsoff2_r[0], LS2_SENSE_OFF};
		end
	end
	logic en_s, above_s, below_s, zero1_s, ss1_s, ss2_s, stp1_s, stp2_s, il1_s, il2_s;
	assign en_s    = s2_r[9];
	assign above_s = s2_r[8];
	assign below_s = s2_r[7];
	assign zero1_s = s2_r[6];
	assign ss1_s   = s2_r[5];
	assign ss2_s   = s2_r[4];
	assign stp1_s  = s2_r[3];
	assign stp2_s  = s2_r[2];
	assign il1_s   = s2_r[1];
	assign il2_s   = s2_r[0];

	// Lockout latch: set below threshold, cleared only after deep discharge
	logic lock_r, lock_nxt, armed_r, armed_nxt;
	always_comb begin
		lock_nxt  = lock_r;
		armed_nxt = armed_r;
		if (!above_s) begin
			if (!lock_r)
				armed_nxt = 1'b0;
			lock_nxt = 1'b1;
		end
		if (below_s)
			armed_nxt = 1'b1;
		if (lock_r && armed_r && above_s)
			lock_nxt = 1'b0;
	end

	// Switching clock from oscillator (system clock) divided down, then by two
	localparam int HALF = OSC_DIV / 2;
	logic [7:0] div_r, div_nxt;
	logic       sw_r, sw_nxt, rise, fall;
	always_comb begin
		div_nxt = div_r + 8'h01;
		sw_nxt  = sw_r;
		rise    = 1'b0;
		fall    = 1'b0;
		if (div_r == 8'(HALF - 1)) begin
			div_nxt = 8'h00;
			sw_nxt  = ~sw_r;
			rise    = ~sw_r;
			fall    = sw_r;
		end
	end

	// Sequencer
	gate_seq_pkg::seq_state_t st_r, st_nxt;
	logic run1, run2, stopped_r, stopped_nxt;
	always_comb begin
		st_nxt      = st_r;
		stopped_nxt = stopped_r;
		case (st_r)
			gate_seq_pkg::SQ_OFF:
				// Level, not edge: enable held high restarts after lockout
				if (en_s && !lock_r) begin
					st_nxt = stopped_r ? gate_seq_pkg::SQ_WAIT_ZERO : gate_seq_pkg::SQ_START1;
				end
			gate_seq_pkg::SQ_WAIT_ZERO:
				if (!en_s)
					st_nxt = gate_seq_pkg::SQ_OFF;
				else if (zero1_s) begin
					st_nxt      = gate_seq_pkg::SQ_START1;
					stopped_nxt = 1'b0;
				end
			gate_seq_pkg::SQ_START1:
				if (!en_s)
					st_nxt = gate_seq_pkg::SQ_STOP1;
				else if (ss1_s)
					st_nxt = gate_seq_pkg::SQ_START2;
			gate_seq_pkg::SQ_START2:
				if (!en_s)
					st_nxt = gate_seq_pkg::SQ_STOP2;
				else if (ss2_s)
					st_nxt = gate_seq_pkg::SQ_RUN;
			gate_seq_pkg::SQ_RUN:
				if (!en_s)
					st_nxt = gate_seq_pkg::SQ_STOP2;
			gate_seq_pkg::SQ_STOP2:
				if (stp2_s)
					st_nxt = gate_seq_pkg::SQ_STOP1;
			gate_seq_pkg::SQ_STOP1:
				if (stp1_s) begin
					st_nxt      = gate_seq_pkg::SQ_OFF;
					stopped_nxt = 1'b1;
				end
			default:
				st_nxt = gate_seq_pkg::SQ_OFF;
		endcase
		if (lock_r) begin
			// Supply loss abandons the sequence; recovery restarts at regulator 1
			st_nxt      = gate_seq_pkg::SQ_OFF;
			stopped_nxt = 1'b0;
		end
	end
	assign run1 = (st_r != gate_seq_pkg::SQ_OFF) && (st_r != gate_seq_pkg::SQ_WAIT_ZERO);
	assign run2 = (st_r == gate_seq_pkg::SQ_START2) || (st_r == gate_seq_pkg::SQ_RUN) ||
		(st_r == gate_seq_pkg::SQ_STOP2);

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			lock_r    <= 1'b1;
			armed_r   <= 1'b0;
			div_r     <= 8'h00;
			sw_r      <= 1'b0;
			st_r      <= gate_seq_pkg::SQ_OFF;
			stopped_r <= 1'b0;
		end else if (CE) begin
			lock_r    <= lock_nxt;
			armed_r   <= armed_nxt;
			div_r     <= div_nxt;
			sw_r      <= sw_nxt;
			st_r      <= st_nxt;
			stopped_r <= stopped_nxt;
		end
	end

	// Per-regulator gate phase logic
	gate_seq_pkg::phase_t ph_r[2], ph_nxt[2];
	logic [3:0]           dt_r[2], dt_nxt[2];
	logic [7:0]           on_r[2], on_nxt[2];
	logic                 hs_r[2], ls_r[2], hs_nxt[2], ls_nxt[2];
	logic                 latch_r[2], latch_nxt[2], il_r[2], il_nxt[2];
	logic                 start_r[2], start_nxt[2];
	logic                 edge_i[2], run_i[2], current_limit_set_i[2], lsoff_i[2];
	logic [`PWM_BITS-1:0] duty_i[2];
	assign edge_i[0]  = rise;
	assign edge_i[1]  = fall;
	assign run_i[0]   = run1;
	assign run_i[1]   = run2;
	assign current_limit_set_i[0]  = il1_s;
	assign current_limit_set_i[1]  = il2_s;
	assign lsoff_i[0] = lsoff1_r[1];
	assign lsoff_i[1] = lsoff2_r[1];
	assign duty_i[0]  = DUTY1;
	assign duty_i[1]  = DUTY2;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ph_nxt[i]    = ph_r[i];
			dt_nxt[i]    = dt_r[i];
			on_nxt[i]    = on_r[i];
			hs_nxt[i]    = hs_r[i];
			ls_nxt[i]    = ls_r[i];
			latch_nxt[i] = latch_r[i];
			il_nxt[i]    = il_r[i];
			start_nxt[i] = start_r[i];
			if (lock_r) begin
				hs_nxt[i]    = 1'b0;
				ls_nxt[i]    = 1'b0;
				latch_nxt[i] = 1'b1;
				start_nxt[i] = 1'b1;
				ph_nxt[i]    = gate_seq_pkg::PH_LS_ON;
			end else if (!run_i[i]) begin
				hs_nxt[i]    = 1'b0;
				// Parked low-side keeps the output from swinging negative
				ls_nxt[i]    = stopped_r && !latch_r[i];
				start_nxt[i] = 1'b1;
				ph_nxt[i]    = gate_seq_pkg::PH_LS_ON;
			end else begin
				case (ph_r[i])
					gate_seq_pkg::PH_LS_ON: begin
						ls_nxt[i] = !latch_r[i];
						if (ls_r[i])
							il_nxt[i] = current_limit_set_i[i];
						if (edge_i[i]) begin
							start_nxt[i] = 1'b0;
							if (start_r[i] && !latch_r[i])
								ph_nxt[i] = gate_seq_pkg::PH_LS_ON;
							else if (il_r[i])
								ph_nxt[i] = gate_seq_pkg::PH_LS_ON;
							else if (duty_i[i] != '0) begin
								ls_nxt[i] = 1'b0;
								ph_nxt[i] = gate_seq_pkg::PH_LS_OFF;
							end
						end
					end
					gate_seq_pkg::PH_LS_OFF:
						if (lsoff_i[i] && !ls_r[i]) begin
							hs_nxt[i] = 1'b1;
							on_nxt[i] = 8'h00;
							ph_nxt[i] = gate_seq_pkg::PH_HS_ON;
						end
					gate_seq_pkg::PH_HS_ON: begin
						on_nxt[i] = on_r[i] + 8'h01;
						if (on_nxt[i] >= 8'(duty_i[i]) || edge_i[i] || on_r[i] >= 8'(HALF * 2 - 2)) begin
							hs_nxt[i]    = 1'b0;
							latch_nxt[i] = 1'b0;
							dt_nxt[i]    = 4'h0;
							il_nxt[i]    = 1'b0;
							ph_nxt[i]    = gate_seq_pkg::PH_DEAD;
						end
					end
					gate_seq_pkg::PH_DEAD: begin
						dt_nxt[i] = dt_r[i] + 4'h1;
						if (dt_r[i] >= 4'(DEAD_CYC - 1)) begin
							ls_nxt[i] = 1'b1;
							ph_nxt[i] = gate_seq_pkg::PH_LS_ON;
						end
					end
					default:
						ph_nxt[i] = gate_seq_pkg::PH_LS_ON;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < 2; i++) begin
				ph_r[i]    <= gate_seq_pkg::PH_LS_ON;
				dt_r[i]    <= 4'h0;
				on_r[i]    <= 8'h00;
				hs_r[i]    <= 1'b0;
				ls_r[i]    <= 1'b0;
				latch_r[i] <= 1'b1;
				il_r[i]    <= 1'b0;
				start_r[i] <= 1'b1;
			end
		end else if (CE) begin
			for (int i = 0; i < 2; i++) begin
				ph_r[i]    <= ph_nxt[i];
				dt_r[i]    <= dt_nxt[i];
				on_r[i]    <= on_nxt[i];
				hs_r[i]    <= hs_nxt[i];
				ls_r[i]    <= ls_nxt[i] && !hs_nxt[i];
				latch_r[i] <= latch_nxt[i];
				il_r[i]    <= il_nxt[i];
				start_r[i] <= start_nxt[i];
			end
		end
	end

	assign HS_GATE_REG1 = hs_r[0];
	assign LS_GATE_REG1 = ls_r[0];
	assign HS_GATE_REG2 = hs_r[1];
	assign LS_GATE_REG2 = ls_r[1];
	assign SWITCH_CLK   = sw_r;
	assign LOCKOUT      = lock_r;
endmodule
`default_nettype wire

//--- fet_pair_model.sv
// Behavioural model of one external power switch pair
`timescale 1ns/100ps
`default_nettype none
module fet_pair_model #(
	parameter int LAG = 1
) (
	input  wire logic clk,
	input  wire logic ls_gate,
	output logic      ls_off
);
	// Gate charge drains over LAG clocks; a larger LAG models a big switch
	int n = 0;
	always @(posedge clk) begin
		n <= ls_gate ? 0 : n + 1;
	end
	assign ls_off = !ls_gate && (n >= LAG);
endmodule
`default_nettype wire

//--- dual_buck_gate_sequencer_asserts.sv
// Port assertions for the gate sequencer
`timescale 1ns/100ps
`default_nettype none
module gate_seq_checker #(
	parameter int OSC_DIV = 16
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CE,
	input wire logic SS1_DONE,
	input wire logic LS1_SENSE_OFF,
	input wire logic HS_GATE_REG1,
	input wire logic LS_GATE_REG1,
	input wire logic HS_GATE_REG2,
	input wire logic LS_GATE_REG2,
	input wire logic SWITCH_CLK,
	input wire logic LOCKOUT
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// Edges since last toggle; zero until the first toggle is seen
	logic sc_q;
	int   cnt;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			sc_q <= 1'h0;
			cnt  <= 0;
		end else if (CE) begin
			sc_q <= SWITCH_CLK;
			cnt  <= (SWITCH_CLK != sc_q) ? 1 : ((cnt != 0) ? cnt + 1 : 0);
		end
	end
	a_no_overlap1: assert property (!(HS_GATE_REG1 && LS_GATE_REG1))
		else $error("overlap reg1");
	a_no_overlap2: assert property (!(HS_GATE_REG2 && LS_GATE_REG2))
		else $error("overlap reg2");
	a_dead_gap: assert property ($rose(LS_GATE_REG1) |-> !$past(HS_GATE_REG1))
		else $error("no dead gap");
	a_hs_waits_ls: assert property ($rose(HS_GATE_REG1) |-> $past(LS1_SENSE_OFF, 2))
		else $error("high side before low off");
	a_lock_gates_low: assert property (LOCKOUT && $past(LOCKOUT) |->
		!(HS_GATE_REG1 || LS_GATE_REG1 || HS_GATE_REG2 || LS_GATE_REG2))
		else $error("gate on in lockout");
	a_reg2_after: assert property ($rose(HS_GATE_REG2) |-> $past(SS1_DONE, 3))
		else $error("reg2 early");
	a_clk_half: assert property (SWITCH_CLK != sc_q && cnt != 0 |-> cnt == OSC_DIV / 2)
		else $error("divider period");
	a_reg1_phase: assert property ($rose(HS_GATE_REG1) |-> SWITCH_CLK)
		else $error("reg1 phase");
	c_hs1: cover property ($rose(HS_GATE_REG1));
	c_hs2: cover property ($rose(HS_GATE_REG2));
	c_unlock: cover property ($fell(LOCKOUT));
endmodule
bind dual_buck_gate_sequencer gate_seq_checker #(.OSC_DIV(OSC_DIV)) chk_u (
	.CLK_SYS, .RST, .CE, .SS1_DONE, .LS1_SENSE_OFF, .HS_GATE_REG1,
	.LS_GATE_REG1, .HS_GATE_REG2, .LS_GATE_REG2, .SWITCH_CLK, .LOCKOUT
);
`default_nettype wire

//--- dual_buck_gate_sequencer_tb_top.sv
// Testbench for the gate sequencer
`timescale 1ns/100ps
`default_nettype none
`include "gate_seq_consts.svh"
module dual_buck_gate_sequencer_tb_top;
	logic                 CLK_SYS, RST, CE, ENABLE, OUT1_AT_ZERO;
	logic                 SUPPLY_ABOVE_LOCKOUT, SUPPLY_BELOW_RELEASE;
	logic                 SS1_DONE, SS2_DONE, SOFTSTOP1_DONE, SOFTSTOP2_DONE;
	logic                 ILIM1_OVER, ILIM2_OVER, LS1_SENSE_OFF, LS2_SENSE_OFF;
	logic [`PWM_BITS-1:0] DUTY1, DUTY2;
	logic                 HS_GATE_REG1, LS_GATE_REG1, HS_GATE_REG2, LS_GATE_REG2;
	logic                 SWITCH_CLK, LOCKOUT;
	int                   fails, checks_done, c1, c2, lo1, bad;
	dual_buck_gate_sequencer #(.OSC_DIV(16)) dut (.CLK_SYS, .RST, .CE, .ENABLE,
		.SUPPLY_ABOVE_LOCKOUT, .SUPPLY_BELOW_RELEASE, .OUT1_AT_ZERO, .SS1_DONE,
		.SS2_DONE, .SOFTSTOP1_DONE, .SOFTSTOP2_DONE, .ILIM1_OVER, .ILIM2_OVER,
		.LS1_SENSE_OFF, .LS2_SENSE_OFF, .DUTY1, .DUTY2, .HS_GATE_REG1,
		.LS_GATE_REG1, .HS_GATE_REG2, .LS_GATE_REG2, .SWITCH_CLK, .LOCKOUT);
	fet_pair_model fet1 (.clk(CLK_SYS), .ls_gate(LS_GATE_REG1), .ls_off(LS1_SENSE_OFF));
	fet_pair_model fet2 (.clk(CLK_SYS), .ls_gate(LS_GATE_REG2), .ls_off(LS2_SENSE_OFF));
	initial begin
		CLK_SYS = 1'h0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end
	task chk(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, s, e);
		end
	endtask
	task conclude;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Counts high-side starts; lat flags low-side on before first high-side fall
	task run(input int n, input bit lat);
		logic h1, h2, fell;
		h1 = HS_GATE_REG1;
		h2 = HS_GATE_REG2;
		fell = 1'h0;
		c1 = 0;
		c2 = 0;
		lo1 = 0;
		bad = 0;
		repeat (n) begin
			@(negedge CLK_SYS);
			c1 += int'(HS_GATE_REG1 && !h1);
			c2 += int'(HS_GATE_REG2 && !h2);
			lo1 += int'(!LS_GATE_REG1);
			if (h1 && !HS_GATE_REG1)
				fell = 1'h1;
			if (lat && !fell && LS_GATE_REG1)
				bad = 1;
			h1 = HS_GATE_REG1;
			h2 = HS_GATE_REG2;
		end
	endtask
	task s_start;
		ENABLE = 1'h1;
		run(300, 1);
		chk(c1 != 0, 1);
		chk(c2, 0);
		chk(bad, 0);
		SS1_DONE = 1'h1;
		SS2_DONE = 1'h1;
		run(300, 0);
		chk(c2 != 0, 1);
	endtask
	task s_width;
		int i, w;
		w = 0;
		for (i = 0; i < 40 && HS_GATE_REG1; i++) @(negedge CLK_SYS);
		for (i = 0; i < 40 && !HS_GATE_REG1; i++) @(negedge CLK_SYS);
		if (i == 40) begin
			fails++;
			conclude;
		end
		while (HS_GATE_REG1 && w < 40) begin
			@(negedge CLK_SYS);
			w++;
		end
		chk(w, 3);
	endtask
	// Clock enable low must freeze gates, divider and lockout
	task s_freeze;
		logic [5:0] held;
		held = {HS_GATE_REG1, LS_GATE_REG1, HS_GATE_REG2, LS_GATE_REG2, SWITCH_CLK, LOCKOUT};
		CE = 1'h0;
		run(40, 0);
		chk(c1 + c2, 0);
		chk({HS_GATE_REG1, LS_GATE_REG1, HS_GATE_REG2, LS_GATE_REG2, SWITCH_CLK, LOCKOUT}, held);
		CE = 1'h1;
		run(40, 0);
		chk(c1 != 0, 1);
	endtask
	task s_current_limit_set;
		ILIM1_OVER = 1'h1;
		run(20, 0);
		run(100, 0);
		chk(c1, 0);
		chk(lo1, 0);
		chk(c2 != 0, 1);
		ILIM1_OVER = 1'h0;
		run(100, 0);
		chk(c1 != 0, 1);
	endtask
	task s_stop;
		ENABLE = 1'h0;
		run(100, 0);
		chk(c1 != 0, 1);
		SOFTSTOP2_DONE = 1'h1;
		run(50, 0);
		run(100, 0);
		chk(c2, 0);
		chk(c1 != 0, 1);
		SOFTSTOP1_DONE = 1'h1;
		run(50, 0);
		run(50, 0);
		chk(c1, 0);
		chk({LS_GATE_REG1, LS_GATE_REG2}, 2'h3);
		SS1_DONE = 1'h0;
		SS2_DONE = 1'h0;
		SOFTSTOP1_DONE = 1'h0;
		SOFTSTOP2_DONE = 1'h0;
		OUT1_AT_ZERO = 1'h0;
		ENABLE = 1'h1;
		run(100, 0);
		chk(c1, 0);
		OUT1_AT_ZERO = 1'h1;
		run(200, 0);
		chk(c1 != 0, 1);
		chk(c2, 0);
	endtask
	task s_lockout;
		SUPPLY_ABOVE_LOCKOUT = 1'h0;
		run(10, 0);
		chk(LOCKOUT, 1'h1);
		chk({HS_GATE_REG1, LS_GATE_REG1, HS_GATE_REG2, LS_GATE_REG2}, 4'h0);
		SUPPLY_ABOVE_LOCKOUT = 1'h1;
		run(20, 0);
		chk(LOCKOUT, 1'h1);
		SUPPLY_BELOW_RELEASE = 1'h1;
		SUPPLY_ABOVE_LOCKOUT = 1'h0;
		run(10, 0);
		SUPPLY_BELOW_RELEASE = 1'h0;
		SUPPLY_ABOVE_LOCKOUT = 1'h1;
		run(300, 1);
		chk(c1 != 0, 1);
		chk(c2, 0);
		chk(bad, 0);
	endtask
	initial begin
		{RST, CE, OUT1_AT_ZERO} = 3'h7;
		{ENABLE, SUPPLY_ABOVE_LOCKOUT, SUPPLY_BELOW_RELEASE, ILIM1_OVER} = 4'h0;
		{SS1_DONE, SS2_DONE, SOFTSTOP1_DONE, SOFTSTOP2_DONE, ILIM2_OVER} = 5'h00;
		DUTY1 = 8'h03;
		DUTY2 = 8'h05;
		fails = 0;
		checks_done = 0;
		repeat (12) @(negedge CLK_SYS);
		RST = 1'h0;
		run(20, 0);
		chk(LOCKOUT, 1'h1);
		SUPPLY_BELOW_RELEASE = 1'h1;
		run(10, 0);
		SUPPLY_BELOW_RELEASE = 1'h0;
		SUPPLY_ABOVE_LOCKOUT = 1'h1;
		run(10, 0);
		chk(LOCKOUT, 1'h0);
		s_start;
		s_width;
		s_freeze;
		s_current_limit_set;
		s_stop;
		s_lockout;
		conclude;
	end
endmodule
`default_nettype wire
